/* File: vid_csr_pkg.sv */
// constants and types shared by the video transmission register block
package vid_csr_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 16;
  localparam int FIFO_DEPTH = 4;
  localparam int CNT_W = 16;
  localparam int VAL_W = 12;
  localparam int DEPTH_W = 8;
  localparam int SCHEME_W = 4;
  // register byte addresses
  localparam logic [15:0] OFS_FORMAT = 16'h060c;
  localparam logic [15:0] OFS_STREAM = 16'h0614;
  localparam logic [15:0] OFS_SHOT = 16'h061c;
  localparam logic [15:0] OFS_TRIG = 16'h062c;
  localparam logic [15:0] OFS_DEPTH = 16'h0630;
  localparam logic [15:0] OFS_SCHEME = 16'h0640;
  localparam logic [15:0] OFS_FEATURE = 16'h0800;
  localparam logic [15:0] OFS_LEGACY = 16'h102c;
  // field positions; quadlet bit 0 is the msb, so bit n sits at 31-n
  localparam int STREAM_BIT = 31;
  localparam int ONESHOT_BIT = 31;
  localparam int MULTI_BIT = 30;
  localparam int COUNT_LSB = 0;
  localparam int TRIG_BIT = 31;
  localparam int LEGACY_BIT = 31;
  localparam int DEPTH_LSB = 24;
  localparam int SCHEME_LSB = 16;
  localparam int PRES_BIT = 31;
  localparam int ONEPUSH_BIT = 26;
  localparam int ONOFF_BIT = 25;
  localparam int AUTO_BIT = 24;
  localparam int VALUE_LSB = 0;
  // reset values
  localparam logic [31:0] FORMAT_RST = 32'h0000_0000;
  localparam logic [11:0] VALUE_RST = 12'h000;
  localparam logic [3:0] SCHEME_RST = 4'h0;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic FEAT_PRESENT = 1'b1;
  // trigger schemes whose trigger bit clears itself
  localparam logic [3:0] SCHEME_A = 4'h0;
  localparam logic [3:0] SCHEME_B = 4'h2;
  localparam logic [3:0] SCHEME_C = 4'h4;
  localparam logic [15:0] ONE_FRAME = 16'h0001;
  typedef enum logic [1:0] {
    XFER_IDLE = 2'b00,
    XFER_STREAM = 2'b01,
    XFER_SINGLE = 2'b11,
    XFER_MULTI = 2'b10
  } xfer_type;
endpackage

/* File: video_transmission_feature_csrs.sv */
// video transmission registers, frame gating, feature control and the frame fifo
`timescale 1ns/1ps
`default_nettype none

module vid_frame_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 4
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic inValid, // word offered
  input wire logic [WIDTH-1:0] inData, // word
  output logic inReady, // room left
  output logic outValid, // word available
  output logic [WIDTH-1:0] outData, // head word
  input wire logic outReady // sink takes head
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_CNT = DEPTH[PW:0];
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);
  typedef struct packed {
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [PW:0] count;
    logic notFull;
    logic notEmpty;
  } fifo_state_type;
  fifo_state_type q, d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  // flags are kept in flops so ready and valid leave the block without logic
  assign push = inValid && q.notFull;
  assign pop = outReady && q.notEmpty;
  assign inReady = q.notFull;
  assign outValid = q.notEmpty;
  assign outData = mem[q.rdPtr];

  always_comb begin
    d = q;
    if (push) begin
      d.wrPtr = (q.wrPtr == LAST_PTR) ? '0 : q.wrPtr + 1'b1;
    end
    if (pop) begin
      d.rdPtr = (q.rdPtr == LAST_PTR) ? '0 : q.rdPtr + 1'b1;
    end
    d.count = q.count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    d.notFull = (d.count != FULL_CNT);
    d.notEmpty = (d.count != '0);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '{wrPtr: '0, rdPtr: '0, count: '0, notFull: 1'b1, notEmpty: 1'b0};
    end else begin
      q <= d;
    end
  end

  // storage needs no reset; only words behind the count are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[q.wrPtr] <= inData;
    end
  end

  // a count past the depth would mean a push was taken while full
  chk_fifo_count: assert property (@(posedge clk) disable iff (sys_rst) q.count <= FULL_CNT)
    else $error("fifo count above depth");
endmodule

// Behaviour
// - stream bit starts and stops continuous frames
// - legacy trigger only fires while streaming
// - packet format frozen while any transfer active
// - priority stream, single, multi; single ignored streaming
// - single request sends one frame, self-clears
// - multi request sends count frames, self-clears
// - multi ignored while stream or single set
// - trigger bit set/reset, self-clears schemes 0,2,4
// - trigger bit reads busy status
// - depth field read only, zero means invalid
// - feature off holds value fixed
// - auto mode camera tracks value continuously
// - manual mode host writes value
// - one-push adjusts once, clears, back to manual
// - value writable only in manual state
// - present feature shows value in use
module video_transmission_feature_csrs (
  input wire logic clk, // 40 MHz system clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [15:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error for unmapped address
  input wire logic pixValid, // sensor word valid
  input wire logic [31:0] pixData, // sensor word
  input wire logic pixLast, // last word of a frame
  output logic pixReady, // fifo can take a word
  output logic txValid, // outgoing word valid
  output logic [31:0] txData, // outgoing word
  output logic txLast, // outgoing last word of frame
  input wire logic txReady, // transmitter takes word
  output logic [31:0] formatOut, // packet format in use
  output logic trigPulse, // one-cycle trigger to sensor
  input wire logic trigAck, // sensor finished a trigger
  input wire logic [7:0] depthIn, // effective data depth
  output logic [11:0] featValue, // feature setting in use
  output logic adjReq, // one-push adjustment request
  input wire logic adjDone, // one-push adjustment finished
  input wire logic [11:0] autoValue // value found by the camera
);
  typedef struct packed {
    vid_csr_pkg::xfer_type mode;
    logic inFrame;
    logic streamEn;
    logic oneShot;
    logic multiShot;
    logic [15:0] count;
    logic [15:0] remain;
    logic trigBusy;
    logic trigPulse;
    logic [3:0] scheme;
    logic [31:0] format;
    logic onOff;
    logic autoMode;
    logic onePush;
    logic [11:0] value;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } csr_state_type;
  csr_state_type q, d;

  logic fifoReady, beat, frameEnd, access, wrEn, busy, manual;
  vid_csr_pkg::xfer_type startMode, curMode;

  function automatic logic isMapped(input logic [15:0] a);
    isMapped = (a == vid_csr_pkg::OFS_FORMAT) || (a == vid_csr_pkg::OFS_STREAM) ||
      (a == vid_csr_pkg::OFS_SHOT) || (a == vid_csr_pkg::OFS_TRIG) ||
      (a == vid_csr_pkg::OFS_DEPTH) || (a == vid_csr_pkg::OFS_SCHEME) ||
      (a == vid_csr_pkg::OFS_FEATURE) || (a == vid_csr_pkg::OFS_LEGACY);
  endfunction

  function automatic logic selfClears(input logic [3:0] s);
    selfClears = (s == vid_csr_pkg::SCHEME_A) || (s == vid_csr_pkg::SCHEME_B) ||
      (s == vid_csr_pkg::SCHEME_C);
  endfunction

  function automatic vid_csr_pkg::xfer_type pickMode(input logic s, input logic o,
                                                     input logic m);
    if (s) begin
      pickMode = vid_csr_pkg::XFER_STREAM;
    end else if (o) begin
      pickMode = vid_csr_pkg::XFER_SINGLE;
    end else if (m) begin
      pickMode = vid_csr_pkg::XFER_MULTI;
    end else begin
      pickMode = vid_csr_pkg::XFER_IDLE;
    end
  endfunction

  assign access = psel && penable;
  assign wrEn = access && q.pready && pwrite;
  assign beat = pixValid && fifoReady;
  assign frameEnd = beat && pixLast;
  assign startMode = pickMode(q.streamEn, q.oneShot, q.multiShot);
  assign curMode = q.inFrame ? q.mode : startMode;
  assign busy = q.streamEn || q.oneShot || q.multiShot || (q.mode != vid_csr_pkg::XFER_IDLE);
  assign manual = q.onOff && !q.autoMode && !q.onePush;

  // frames are chosen whole at their first word, so a stop never cuts a frame
  vid_frame_fifo #(
    .WIDTH(vid_csr_pkg::DATA_W + 1),
    .DEPTH(vid_csr_pkg::FIFO_DEPTH)
  ) frameFifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .inValid(pixValid && (curMode != vid_csr_pkg::XFER_IDLE)),
    .inData({pixLast, pixData}),
    .inReady(fifoReady),
    .outValid(txValid),
    .outData({txLast, txData}),
    .outReady(txReady)
  );

  always_comb begin
    d = q;
    d.trigPulse = 1'b0;
    // frame gating; hardware clears come before host writes so a set wins
    if (beat) begin
      d.inFrame = !pixLast;
      d.mode = pixLast ? vid_csr_pkg::XFER_IDLE : curMode;
    end
    if (frameEnd) begin
      case (curMode)
        vid_csr_pkg::XFER_SINGLE: begin
          d.oneShot = 1'b0;
        end
        vid_csr_pkg::XFER_MULTI: begin
          if (q.remain <= vid_csr_pkg::ONE_FRAME) begin
            d.multiShot = 1'b0;
            d.remain = '0;
          end else begin
            d.remain = q.remain - vid_csr_pkg::ONE_FRAME;
          end
        end
        default: begin
          d.remain = q.remain;
        end
      endcase
    end
    if (q.trigBusy && trigAck && selfClears(q.scheme)) begin
      d.trigBusy = 1'b0;
    end
    if (q.onOff && q.autoMode) begin
      d.value = autoValue;
    end
    if (q.onOff && !q.autoMode && q.onePush && adjDone) begin
      d.value = autoValue;
      d.onePush = 1'b0;
    end
    // apb: one wait state, read data captured before pready
    d.pready = access && !q.pready;
    d.pslverr = access && !q.pready && !isMapped(paddr);
    if (access && !q.pready) begin
      d.prdata = '0;
      case (paddr)
        vid_csr_pkg::OFS_FORMAT: d.prdata = q.format;
        vid_csr_pkg::OFS_STREAM: d.prdata[vid_csr_pkg::STREAM_BIT] = q.streamEn;
        vid_csr_pkg::OFS_SHOT: begin
          d.prdata[vid_csr_pkg::ONESHOT_BIT] = q.oneShot;
          d.prdata[vid_csr_pkg::MULTI_BIT] = q.multiShot;
          d.prdata[vid_csr_pkg::COUNT_LSB +: vid_csr_pkg::CNT_W] = q.count;
        end
        vid_csr_pkg::OFS_TRIG: d.prdata[vid_csr_pkg::TRIG_BIT] = q.trigBusy;
        vid_csr_pkg::OFS_DEPTH: d.prdata[vid_csr_pkg::DEPTH_LSB +: vid_csr_pkg::DEPTH_W] = depthIn;
        vid_csr_pkg::OFS_SCHEME: d.prdata[vid_csr_pkg::SCHEME_LSB +: vid_csr_pkg::SCHEME_W] = q.scheme;
        vid_csr_pkg::OFS_FEATURE: begin
          d.prdata[vid_csr_pkg::PRES_BIT] = vid_csr_pkg::FEAT_PRESENT;
          d.prdata[vid_csr_pkg::ONEPUSH_BIT] = q.onePush;
          d.prdata[vid_csr_pkg::ONOFF_BIT] = q.onOff;
          d.prdata[vid_csr_pkg::AUTO_BIT] = q.autoMode;
          d.prdata[vid_csr_pkg::VALUE_LSB +: vid_csr_pkg::VAL_W] = q.value;
        end
        default: d.prdata = '0;
      endcase
    end
    if (wrEn) begin
      case (paddr)
        vid_csr_pkg::OFS_FORMAT: begin
          if (!busy) begin
            d.format = pwdata;
          end
        end
        vid_csr_pkg::OFS_STREAM: d.streamEn = pwdata[vid_csr_pkg::STREAM_BIT];
        vid_csr_pkg::OFS_SHOT: begin
          d.count = pwdata[vid_csr_pkg::COUNT_LSB +: vid_csr_pkg::CNT_W];
          if (!q.streamEn) begin
            d.oneShot = pwdata[vid_csr_pkg::ONESHOT_BIT] || d.oneShot;
          end
          // a zero count would send nothing, so the request is not taken
          if (!q.streamEn && !q.oneShot && !pwdata[vid_csr_pkg::ONESHOT_BIT] &&
              pwdata[vid_csr_pkg::MULTI_BIT] && (d.count != '0)) begin
            d.multiShot = 1'b1;
            d.remain = d.count;
          end
        end
        vid_csr_pkg::OFS_TRIG: begin
          d.trigBusy = pwdata[vid_csr_pkg::TRIG_BIT];
          d.trigPulse = pwdata[vid_csr_pkg::TRIG_BIT] && !q.trigBusy;
        end
        vid_csr_pkg::OFS_LEGACY: begin
          d.trigPulse = pwdata[vid_csr_pkg::LEGACY_BIT] && q.streamEn;
        end
        vid_csr_pkg::OFS_SCHEME: begin
          d.scheme = pwdata[vid_csr_pkg::SCHEME_LSB +: vid_csr_pkg::SCHEME_W];
        end
        vid_csr_pkg::OFS_FEATURE: begin
          d.onOff = pwdata[vid_csr_pkg::ONOFF_BIT];
          d.autoMode = pwdata[vid_csr_pkg::AUTO_BIT];
          // one-push is only meaningful from manual; auto or off cancels it
          d.onePush = pwdata[vid_csr_pkg::ONOFF_BIT] && !pwdata[vid_csr_pkg::AUTO_BIT] &&
            (pwdata[vid_csr_pkg::ONEPUSH_BIT] || d.onePush);
          if (manual) begin
            d.value = pwdata[vid_csr_pkg::VALUE_LSB +: vid_csr_pkg::VAL_W];
          end
        end
        default: d.format = d.format;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '{mode: vid_csr_pkg::XFER_IDLE, inFrame: 1'b0, streamEn: 1'b0, oneShot: 1'b0,
             multiShot: 1'b0, count: vid_csr_pkg::COUNT_RST, remain: '0, trigBusy: 1'b0,
             trigPulse: 1'b0, scheme: vid_csr_pkg::SCHEME_RST,
             format: vid_csr_pkg::FORMAT_RST, onOff: 1'b0, autoMode: 1'b0, onePush: 1'b0,
             value: vid_csr_pkg::VALUE_RST, pready: 1'b0, pslverr: 1'b0, prdata: '0};
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign pixReady = fifoReady;
  assign formatOut = q.format;
  assign trigPulse = q.trigPulse;
  assign featValue = q.value;
  assign adjReq = q.onePush;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_stream_start: assert property (beat && !q.inFrame && q.streamEn && !pixLast
    |=> q.mode == vid_csr_pkg::XFER_STREAM) else $error("stream frame not started");
  chk_legacy_gate: assert property (wrEn && paddr == vid_csr_pkg::OFS_LEGACY && !q.streamEn
    && !q.trigBusy |=> !trigPulse) else $error("legacy trigger fired without stream");
  chk_format_hold: assert property (busy && !$past(sys_rst) |=> $stable(formatOut))
    else $error("packet format changed while busy");
  chk_single_ignored: assert property (wrEn && paddr == vid_csr_pkg::OFS_SHOT
    && q.streamEn && !q.oneShot |=> !q.oneShot) else $error("single taken while streaming");
  chk_single_clear: assert property (frameEnd && curMode == vid_csr_pkg::XFER_SINGLE
    && !wrEn |=> !q.oneShot) else $error("single request not cleared");
  chk_multi_done: assert property (frameEnd && curMode == vid_csr_pkg::XFER_MULTI && !wrEn
    && q.remain == vid_csr_pkg::ONE_FRAME |=> !q.multiShot) else $error("multi not cleared");
  chk_multi_ignored: assert property (wrEn && paddr == vid_csr_pkg::OFS_SHOT && !q.multiShot
    && (q.streamEn || q.oneShot) |=> !q.multiShot) else $error("multi taken while blocked");
  chk_trig_selfclr: assert property (q.trigBusy && trigAck && selfClears(q.scheme) && !wrEn
    |=> !q.trigBusy) else $error("trigger bit not self-cleared");
  chk_trig_status: assert property (access && !q.pready && paddr == vid_csr_pkg::OFS_TRIG
    |=> pready && prdata[vid_csr_pkg::TRIG_BIT] == $past(q.trigBusy))
    else $error("trigger status read wrong");
  chk_depth_read: assert property (access && !q.pready && paddr == vid_csr_pkg::OFS_DEPTH
    |=> prdata == {$past(depthIn), 24'h000000}) else $error("depth read wrong");
  chk_off_fixed: assert property (!q.onOff |=> $stable(featValue))
    else $error("value moved while feature off");
  chk_auto_track: assert property (q.onOff && q.autoMode |=> featValue == $past(autoValue))
    else $error("auto value not tracked");
  chk_manual_write: assert property (wrEn && paddr == vid_csr_pkg::OFS_FEATURE && manual
    |=> featValue == $past(pwdata[11:0])) else $error("manual write lost");
  chk_onepush_end: assert property (q.onOff && !q.autoMode && q.onePush && adjDone && !wrEn
    |=> !adjReq && featValue == $past(autoValue)) else $error("one-push not finished");
  chk_apb_answer: assert property (access && !q.pready |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
  chk_value_locked: assert property (wrEn && paddr == vid_csr_pkg::OFS_FEATURE && !manual
    && !(q.onOff && q.autoMode) && !adjDone |=> $stable(featValue))
    else $error("value written outside manual");
  chk_legacy_fire: assert property (wrEn && paddr == vid_csr_pkg::OFS_LEGACY
    && pwdata[vid_csr_pkg::LEGACY_BIT] && q.streamEn |=> trigPulse)
    else $error("legacy trigger lost");
  chk_trig_set: assert property (wrEn && paddr == vid_csr_pkg::OFS_TRIG
    && pwdata[vid_csr_pkg::TRIG_BIT] |=> q.trigBusy) else $error("trigger bit not set");
  chk_multi_count: assert property (frameEnd && curMode == vid_csr_pkg::XFER_MULTI
    && !wrEn && q.remain > vid_csr_pkg::ONE_FRAME
    |=> q.remain == $past(q.remain) - vid_csr_pkg::ONE_FRAME)
    else $error("multi count not stepped");

  cov_stream_frame: cover property (q.mode == vid_csr_pkg::XFER_STREAM ##[1:50] frameEnd);
  cov_single_frame: cover property (q.oneShot ##[1:100] !q.oneShot);
  cov_multi_frames: cover property (q.multiShot && q.remain > vid_csr_pkg::ONE_FRAME
    ##[1:200] !q.multiShot);
  cov_fifo_full: cover property (pixValid && !pixReady);
  cov_onepush_done: cover property (adjReq ##[1:20] !adjReq);
endmodule

`default_nettype wire

/* File: vid_far_side.sv */
// sensor source, transmitter sink and the trigger and adjust responders
`timescale 1ns/1ps
`default_nettype none
module vid_far_side (
  input wire logic clk, // system clock
  input wire logic frameGo, // start one two-word frame
  input wire logic stall, // sink refuses words
  input wire logic pixReady, // fifo has room
  output logic pixValid, // word offered
  output logic [31:0] pixData, // word
  output logic pixLast, // last word of frame
  input wire logic txValid, // fifo head valid
  input wire logic txLast, // head ends a frame
  output logic txReady, // sink takes head
  input wire logic trigPulse, // trigger issued
  output logic trigAck, // trigger finished
  input wire logic adjReq, // adjustment running
  output logic adjDone, // adjustment finished
  output int frames // frames taken by the sink
);
  logic [1:0] left = 2'd0;
  logic [31:0] seq = 32'h0000_0001;
  logic [2:0] tDel = 3'd0;
  logic [2:0] aCnt = 3'd0;
  logic ackQ = 1'b0;
  logic doneQ = 1'b0;
  int seen = 0;
  assign trigAck = ackQ;
  assign adjDone = doneQ;
  assign frames = seen;
  assign txReady = !stall;
  assign pixValid = left != 2'd0;
  assign pixLast = left == 2'd1;
  // idle data line flips so a stale word never looks valid
  assign pixData = pixValid ? seq : ~seq;
  always @(posedge clk) begin
    if (frameGo) begin
      left <= 2'd2;
    end else if (pixValid && pixReady) begin
      left <= left - 2'd1;
      seq <= seq + 32'h1;
    end
    if (txValid && txReady && txLast) begin
      seen <= seen + 1;
    end
    // slow ack so the busy state can be read back
    tDel <= trigPulse ? 3'd7 : (tDel != 3'd0 ? tDel - 3'd1 : 3'd0);
    ackQ <= tDel == 3'd1;
    aCnt <= adjReq ? aCnt + 3'd1 : 3'd0;
    doneQ <= aCnt == 3'd2;
  end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the video transmission register block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [15:0] FMT = vid_csr_pkg::OFS_FORMAT;
  localparam logic [15:0] STR = vid_csr_pkg::OFS_STREAM;
  localparam logic [15:0] SHT = vid_csr_pkg::OFS_SHOT;
  localparam logic [15:0] TRG = vid_csr_pkg::OFS_TRIG;
  localparam logic [15:0] FEA = vid_csr_pkg::OFS_FEATURE;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pixValid, pixLast, pixReady, txValid, txLast, txReady, trigPulse, trigAck;
  logic [31:0] pixData, txData, formatOut;
  logic [7:0] depthIn = 8'h0c;
  logic [11:0] featValue, autoValue = 12'h5a5;
  logic adjReq, adjDone, err, frameGo = 1'b0, stall = 1'b0;
  int frames, f0, p0, mismatches = 0, comparisons = 0, pulses = 0, cyc = 0;
  always #12.5 clk = ~clk;
  video_transmission_feature_csrs dut (.clk(clk), .sys_rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pixValid(pixValid), .pixData(pixData),
    .pixLast(pixLast), .pixReady(pixReady), .txValid(txValid), .txData(txData),
    .txLast(txLast), .txReady(txReady), .formatOut(formatOut), .trigPulse(trigPulse),
    .trigAck(trigAck), .depthIn(depthIn), .featValue(featValue), .adjReq(adjReq),
    .adjDone(adjDone), .autoValue(autoValue));
  vid_far_side far (.clk(clk), .frameGo(frameGo), .stall(stall), .pixReady(pixReady),
    .pixValid(pixValid), .pixData(pixData), .pixLast(pixLast), .txValid(txValid),
    .txLast(txLast), .txReady(txReady), .trigPulse(trigPulse), .trigAck(trigAck),
    .adjReq(adjReq), .adjDone(adjDone), .frames(frames));
  task automatic wrap_up();
    $display("counts: comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (trigPulse === 1'b1) pulses <= pulses + 1;
    // ceiling well above the few hundred cycles the tests need
    if (cyc == 20000) begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask
  // one apb transfer; waits on pready, then idles one cycle
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic go(input int n);
    frameGo <= 1'b1;
    @(posedge clk);
    frameGo <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic t_regs();
    rdchk(STR, 32'h0);
    rdchk(SHT, 32'h0);
    rdchk(TRG, 32'h0);
    wr(vid_csr_pkg::OFS_DEPTH, 32'hffff_ffff);
    rdchk(vid_csr_pkg::OFS_DEPTH, 32'h0c00_0000);
    rdchk(FEA, 32'h8000_0000);
    rdchk(16'h0004, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test regs done");
  endtask
  task automatic t_stream();
    wr(FMT, 32'h1234_5678);
    wr(STR, 32'h8000_0000);
    wr(FMT, 32'hdead_beef);
    rdchk(FMT, 32'h1234_5678);
    chk(formatOut, 32'h1234_5678);
    f0 = frames;
    stall <= 1'b1;
    go(6);
    go(6);
    go(6);
    chk({31'h0, pixReady}, 32'h0);
    chk({31'h0, txValid}, 32'h1);
    chk(txData, 32'h0000_0001);
    chk({31'h0, txLast}, 32'h0);
    stall <= 1'b0;
    repeat (20) @(posedge clk);
    chk(frames, f0 + 3);
    wr(STR, 32'h0);
    go(20);
    chk(frames, f0 + 3);
    chk({31'h0, txValid}, 32'h0);
    $display("test stream done");
  endtask
  task automatic t_shots();
    wr(STR, 32'h8000_0000);
    wr(SHT, 32'h8000_0000);
    rdchk(SHT, 32'h0);
    wr(SHT, 32'h4000_0002);
    apb(1'b0, SHT, 32'h0);
    chk({31'h0, rd[30]}, 32'h0);
    wr(STR, 32'h0);
    f0 = frames;
    wr(SHT, 32'h8000_0000);
    wr(SHT, 32'h4000_0002);
    rdchk(SHT, 32'h8000_0002);
    go(12);
    go(12);
    chk(frames, f0 + 1);
    rdchk(SHT, 32'h0000_0002);
    f0 = frames;
    wr(SHT, 32'h4000_0002);
    go(12);
    go(12);
    go(12);
    chk(frames, f0 + 2);
    apb(1'b0, SHT, 32'h0);
    chk({31'h0, rd[30]}, 32'h0);
    $display("test shots done");
  endtask
  task automatic t_trig();
    logic [3:0] sch [3] = '{vid_csr_pkg::SCHEME_A, vid_csr_pkg::SCHEME_B, vid_csr_pkg::SCHEME_C};
    for (int i = 0; i < 3; i++) begin
      wr(vid_csr_pkg::OFS_SCHEME, {12'h0, sch[i], 16'h0});
      p0 = pulses;
      wr(TRG, 32'h8000_0000);
      rdchk(TRG, 32'h8000_0000);
      repeat (12) @(posedge clk);
      rdchk(TRG, 32'h0);
      chk(pulses, p0 + 1);
    end
    wr(vid_csr_pkg::OFS_SCHEME, 32'h0001_0000);
    wr(TRG, 32'h8000_0000);
    repeat (12) @(posedge clk);
    rdchk(TRG, 32'h8000_0000);
    wr(TRG, 32'h0);
    rdchk(TRG, 32'h0);
    p0 = pulses;
    wr(vid_csr_pkg::OFS_LEGACY, 32'h8000_0000);
    repeat (2) @(posedge clk);
    chk(pulses, p0);
    wr(STR, 32'h8000_0000);
    wr(vid_csr_pkg::OFS_LEGACY, 32'h8000_0000);
    repeat (2) @(posedge clk);
    chk(pulses, p0 + 1);
    wr(STR, 32'h0);
    $display("test trigger done");
  endtask
  task automatic t_feature();
    wr(FEA, 32'h0000_0123);
    rdchk(FEA, 32'h8000_0000);
    wr(FEA, 32'h0200_0000);
    wr(FEA, 32'h0200_0abc);
    rdchk(FEA, 32'h8200_0abc);
    chk(featValue, 12'habc);
    wr(FEA, 32'h0300_0111);
    @(posedge clk);
    chk(featValue, 12'h5a5);
    autoValue <= 12'h333;
    repeat (3) @(posedge clk);
    rdchk(FEA, 32'h8300_0333);
    wr(FEA, 32'h0200_0000);
    autoValue <= 12'h246;
    wr(FEA, 32'h0600_0000);
    chk({31'h0, adjReq}, 32'h1);
    repeat (12) @(posedge clk);
    chk({31'h0, adjReq}, 32'h0);
    rdchk(FEA, 32'h8200_0246);
    $display("test feature done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_stream();
    t_shots();
    t_trig();
    t_feature();
    wrap_up();
  end
endmodule
`default_nettype wire
